// file: shared/mcsr_pkg.sv
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package mcsr_pkg;

  // Register addresses as seen on the serial register port.
  localparam logic [15:0] ADDR_B_FIRMS  = 16'he530;
  localparam logic [15:0] ADDR_A_FIRMS  = 16'he537;
  localparam logic [15:0] ADDR_A_FVRMS  = 16'he538;
  localparam logic [15:0] ADDR_B_FVRMS  = 16'he53a;
  localparam logic [15:0] ADDR_C_FIRMS  = 16'he53b;
  localparam logic [15:0] ADDR_C_FVRMS  = 16'he53c;
  localparam logic [15:0] ADDR_CAPTURE  = 16'he5ff;
  localparam logic [15:0] ADDR_PEAKST   = 16'he600;
  localparam logic [15:0] ADDR_DELAY0   = 16'he601;
  localparam logic [15:0] ADDR_DELAY1   = 16'he602;
  localparam logic [15:0] ADDR_DELAY2   = 16'he603;
  localparam logic [15:0] ADDR_NOLOAD   = 16'he608;
  localparam logic [15:0] ADDR_LCOUNT   = 16'he60c;
  localparam logic [15:0] ADDR_ZXTMO    = 16'he60d;
  localparam logic [15:0] ADDR_COMPSET  = 16'he60e;
  localparam logic [15:0] ADDR_FOUTSET  = 16'he610;
  localparam logic [15:0] ADDR_FDIV1    = 16'he611;
  localparam logic [15:0] ADDR_FDIV2    = 16'he612;
  localparam logic [15:0] ADDR_FDIV3    = 16'he613;
  localparam logic [15:0] ADDR_TRIM_A   = 16'he614;
  localparam logic [15:0] ADDR_TRIM_B   = 16'he615;
  localparam logic [15:0] ADDR_TRIM_C   = 16'he616;
  localparam logic [15:0] ADDR_PSIGN    = 16'he617;
  localparam logic [15:0] ADDR_MAINSET  = 16'he618;
  localparam logic [15:0] ADDR_MEASSET  = 16'he700;
  localparam logic [15:0] ADDR_ACCSET   = 16'he701;
  localparam logic [15:0] ADDR_LACCBEH  = 16'he702;
  localparam logic [15:0] ADDR_PEAKWIN  = 16'he703;

  // Field widths.
  localparam int RMS_W  = 24;
  localparam int TRIM_W = 10;

  // Reset values of the writable registers.
  localparam logic [15:0] RST_LCOUNT  = 16'hffff;
  localparam logic [15:0] RST_ZXTMO   = 16'hffff;
  localparam logic [15:0] RST_COMPSET = 16'h01ff;
  localparam logic [15:0] RST_FOUTSET = 16'h0e88;
  localparam logic [15:0] RST_FDIV    = 16'h0000;
  localparam logic [9:0]  RST_TRIM    = 10'h000;
  localparam logic [15:0] RST_MAINSET = 16'h0010;
  localparam logic [7:0]  RST_MEASSET = 8'h1c;
  localparam logic [7:0]  RST_ACCSET  = 8'h00;
  localparam logic [7:0]  RST_LACCBEH = 8'h78;
  localparam logic [7:0]  RST_PEAKWIN = 8'h00;

endpackage

// file: logic/mcsr_regs.sv
`timescale 1ns/100ps
module mcsr_regs
#(
  parameter int PEAK_W = 8                 // Peak window register width.
)
(
  input  wire logic        clk_in,         // 125 MHz device clock.
  input  wire logic        rst_in,         // Async reset, active high.
  input  wire logic        req_valid_in,   // Register request strobe.
  input  wire logic        req_write_in,   // High for write, low for read.
  input  wire logic [15:0] req_addr_in,    // Register address.
  input  wire logic [31:0] req_wdata_in,   // Write data, low aligned.
  output logic             resp_valid_out, // Answer strobe.
  output logic      [31:0] resp_rdata_out, // Read data.
  output logic             resp_error_out, // Address not in this bank.
  input  wire logic        xfer32_in,      // Other 32-bit transfer done.
  input  wire logic [31:0] xfer32_data_in, // Its data word.
  input  wire logic [23:0] a_irms_in,      // Phase A fund. current rms.
  input  wire logic [23:0] a_vrms_in,      // Phase A fund. voltage rms.
  input  wire logic [23:0] b_irms_in,      // Phase B fund. current rms.
  input  wire logic [23:0] b_vrms_in,      // Phase B fund. voltage rms.
  input  wire logic [23:0] c_irms_in,      // Phase C fund. current rms.
  input  wire logic [23:0] c_vrms_in,      // Phase C fund. voltage rms.
  input  wire logic [15:0] peak_status_in, // Peak result flags.
  input  wire logic [15:0] delay0_in,      // Inter-phase delay 0.
  input  wire logic [15:0] delay1_in,      // Inter-phase delay 1.
  input  wire logic [15:0] delay2_in,      // Inter-phase delay 2.
  input  wire logic [15:0] noload_in,      // No-load flags.
  input  wire logic [15:0] psign_in,       // Power sign flags.
  input  wire logic        half_cycle_in,  // Half line cycle pulse.
  output logic             peak_done_out,  // Peak window end pulse.
  output logic      [15:0] lcount_out,     // Line cycle count.
  output logic      [15:0] zxtmo_out,      // Zero-cross timeout.
  output logic      [15:0] compset_out,    // Computation setup.
  output logic      [15:0] foutset_out,    // Freq output setup.
  output logic      [15:0] fdiv1_out,      // Freq output 1 divisor.
  output logic      [15:0] fdiv2_out,      // Freq output 2 divisor.
  output logic      [15:0] fdiv3_out,      // Freq output 3 divisor.
  output logic       [9:0] trim_a_out,     // Phase A phase trim.
  output logic       [9:0] trim_b_out,     // Phase B phase trim.
  output logic       [9:0] trim_c_out,     // Phase C phase trim.
  output logic      [15:0] mainset_out,    // Main setup.
  output logic       [7:0] measset_out,    // Measurement setup.
  output logic       [7:0] accset_out,     // Accumulation setup.
  output logic       [7:0] laccbeh_out     // Line accumulation behaviour.
);
  import mcsr_pkg::*;

  //--------------------------------------------------------------------
  // Parameter check
  //--------------------------------------------------------------------
  // The peak window register is carried on an 8-bit transfer.
  if (PEAK_W != 8)
  begin : g_chk
    $error("PEAK_W must be 8");
  end

  //--------------------------------------------------------------------
  // Helpers and state
  //--------------------------------------------------------------------
  // Zero pads an unsigned rms result into a 32-bit transfer word.
  function automatic logic [31:0] zpad24(input logic [23:0] v);
    zpad24 = {8'h00, v};
  endfunction

  logic [31:0] capture;         // Last good 32-bit word.
  logic [31:0] next_rdata;      // Read data chosen this cycle.
  logic        next_error;      // Address decoded as unmapped.
  logic        next_is32;       // Address is a 32-bit register.
  logic [PEAK_W-1:0] peakwin;   // Peak window in half cycles.
  logic [PEAK_W-1:0] peak_cnt;  // Half cycles seen in window.
  logic        wr;              // Write strobe for this bank.

  assign wr = req_valid_in && req_write_in;

  //--------------------------------------------------------------------
  // Read decode
  //--------------------------------------------------------------------
  // Picks the read word; reserved gaps answer with an error.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_error = 1'b0;
    next_is32  = 1'b0;
    case (req_addr_in)
      ADDR_A_FIRMS:
      begin
        next_rdata = zpad24(a_irms_in);
        next_is32  = 1'b1;
      end
      ADDR_A_FVRMS:
      begin
        next_rdata = zpad24(a_vrms_in);
        next_is32  = 1'b1;
      end
      ADDR_B_FIRMS:
      begin
        next_rdata = zpad24(b_irms_in);
        next_is32  = 1'b1;
      end
      ADDR_B_FVRMS:
      begin
        next_rdata = zpad24(b_vrms_in);
        next_is32  = 1'b1;
      end
      ADDR_C_FIRMS:
      begin
        next_rdata = zpad24(c_irms_in);
        next_is32  = 1'b1;
      end
      ADDR_C_FVRMS:
      begin
        next_rdata = zpad24(c_vrms_in);
        next_is32  = 1'b1;
      end
      ADDR_CAPTURE:
      begin
        next_rdata = capture;
        next_is32  = 1'b1;
      end
      ADDR_PEAKST:  next_rdata = {16'h0000, peak_status_in};
      ADDR_DELAY0:  next_rdata = {16'h0000, delay0_in};
      ADDR_DELAY1:  next_rdata = {16'h0000, delay1_in};
      ADDR_DELAY2:  next_rdata = {16'h0000, delay2_in};
      ADDR_NOLOAD:  next_rdata = {16'h0000, noload_in};
      ADDR_PSIGN:   next_rdata = {16'h0000, psign_in};
      ADDR_LCOUNT:  next_rdata = {16'h0000, lcount_out};
      ADDR_ZXTMO:   next_rdata = {16'h0000, zxtmo_out};
      ADDR_COMPSET: next_rdata = {16'h0000, compset_out};
      ADDR_FOUTSET: next_rdata = {16'h0000, foutset_out};
      ADDR_FDIV1:   next_rdata = {16'h0000, fdiv1_out};
      ADDR_FDIV2:   next_rdata = {16'h0000, fdiv2_out};
      ADDR_FDIV3:   next_rdata = {16'h0000, fdiv3_out};
      ADDR_TRIM_A:  next_rdata = {22'h0, trim_a_out};
      ADDR_TRIM_B:  next_rdata = {22'h0, trim_b_out};
      ADDR_TRIM_C:  next_rdata = {22'h0, trim_c_out};
      ADDR_MAINSET: next_rdata = {16'h0000, mainset_out};
      ADDR_MEASSET: next_rdata = {24'h000000, measset_out};
      ADDR_ACCSET:  next_rdata = {24'h000000, accset_out};
      ADDR_LACCBEH: next_rdata = {24'h000000, laccbeh_out};
      ADDR_PEAKWIN: next_rdata = {24'h000000, peakwin};
      // Reserved gaps and foreign addresses: nothing is stored.
      default:      next_error = 1'b1;
    endcase
  end

  //--------------------------------------------------------------------
  // Answer
  //--------------------------------------------------------------------
  // Every request is answered one clock later; writes read as zero.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      resp_valid_out <= 1'b0;
      resp_rdata_out <= 32'h0000_0000;
      resp_error_out <= 1'b0;
    end
    else
    begin
      resp_valid_out <= req_valid_in;
      resp_error_out <= req_valid_in && next_error;
      if (req_valid_in && !req_write_in)
        resp_rdata_out <= next_rdata;
      else
        resp_rdata_out <= 32'h0000_0000;
    end
  end

  //--------------------------------------------------------------------
  // Last word capture
  //--------------------------------------------------------------------
  // A read of a 32-bit register here wins over a foreign transfer.
  // Writes to the 32-bit registers are ignored without an error, so never captured.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      capture <= 32'h0000_0000;
    else if (req_valid_in && !req_write_in && next_is32)
      capture <= next_rdata;
    else if (xfer32_in)
      capture <= xfer32_data_in;
  end

  //--------------------------------------------------------------------
  // Writable registers
  //--------------------------------------------------------------------
  // Counts and setups; read-only addresses have no write path here.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lcount_out  <= RST_LCOUNT;
      zxtmo_out   <= RST_ZXTMO;
      compset_out <= RST_COMPSET;
      foutset_out <= RST_FOUTSET;
      fdiv1_out   <= RST_FDIV;
      fdiv2_out   <= RST_FDIV;
      fdiv3_out   <= RST_FDIV;
      mainset_out <= RST_MAINSET;
    end
    else if (wr)
    begin
      case (req_addr_in)
        ADDR_LCOUNT:  lcount_out  <= req_wdata_in[15:0];
        ADDR_ZXTMO:   zxtmo_out   <= req_wdata_in[15:0];
        ADDR_COMPSET: compset_out <= req_wdata_in[15:0];
        ADDR_FOUTSET: foutset_out <= req_wdata_in[15:0];
        ADDR_FDIV1:   fdiv1_out   <= req_wdata_in[15:0];
        ADDR_FDIV2:   fdiv2_out   <= req_wdata_in[15:0];
        ADDR_FDIV3:   fdiv3_out   <= req_wdata_in[15:0];
        ADDR_MAINSET: mainset_out <= req_wdata_in[15:0];
        default:      ;
      endcase
    end
  end

  // Phase trims keep only their ten significant bits.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      trim_a_out <= RST_TRIM;
      trim_b_out <= RST_TRIM;
      trim_c_out <= RST_TRIM;
    end
    else if (wr)
    begin
      case (req_addr_in)
        ADDR_TRIM_A: trim_a_out <= req_wdata_in[TRIM_W-1:0];
        ADDR_TRIM_B: trim_b_out <= req_wdata_in[TRIM_W-1:0];
        ADDR_TRIM_C: trim_c_out <= req_wdata_in[TRIM_W-1:0];
        default:     ;
      endcase
    end
  end

  // Byte-wide mode registers.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      measset_out <= RST_MEASSET;
      accset_out  <= RST_ACCSET;
      laccbeh_out <= RST_LACCBEH;
      peakwin     <= RST_PEAKWIN;
    end
    else if (wr)
    begin
      case (req_addr_in)
        ADDR_MEASSET: measset_out <= req_wdata_in[7:0];
        ADDR_ACCSET:  accset_out  <= req_wdata_in[7:0];
        ADDR_LACCBEH: laccbeh_out <= req_wdata_in[7:0];
        ADDR_PEAKWIN: peakwin     <= req_wdata_in[PEAK_W-1:0];
        default:      ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Peak window timer
  //--------------------------------------------------------------------
  // Counts half line cycles and pulses at the end of each window.
  // A zero window stops the timer; rewriting the window restarts it.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      peak_cnt      <= '0;
      peak_done_out <= 1'b0;
    end
    else if ((wr && req_addr_in == ADDR_PEAKWIN) || peakwin == '0)
    begin
      peak_cnt      <= '0;
      peak_done_out <= 1'b0;
    end
    else if (half_cycle_in && peak_cnt + 1'b1 == peakwin)
    begin
      peak_cnt      <= '0;
      peak_done_out <= 1'b1;
    end
    else
    begin
      peak_cnt      <= peak_cnt + PEAK_W'(half_cycle_in);
      peak_done_out <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  rms_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && req_addr_in == ADDR_A_FIRMS
    |=> resp_rdata_out == {8'h00, $past(a_irms_in)})
    else $error("rms read word wrong");

  capture_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && next_is32
    |=> capture == resp_rdata_out)
    else $error("capture not last 32-bit word");

  trim_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr && req_addr_in == ADDR_TRIM_B
    |=> trim_b_out == $past(req_wdata_in[9:0]))
    else $error("trim write wrong");

  count_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> lcount_out == 16'hffff
    && zxtmo_out == 16'hffff)
    else $error("count reset values wrong");

  fout_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> foutset_out == 16'h0e88 && fdiv1_out == 16'h0000
    && fdiv3_out == 16'h0000)
    else $error("output setup reset wrong");

  lacc_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> laccbeh_out == 8'h78 && peakwin == 8'h00)
    else $error("byte setup reset wrong");

  peak_window_a: assert property (@(posedge clk_in) disable iff (rst_in)
    peakwin == 8'h02 && !wr && peak_cnt == 8'h01 && half_cycle_in
    |=> peak_done_out && peak_cnt == 8'h00)
    else $error("peak window end missed");

  delay_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && req_addr_in == ADDR_DELAY2
    |=> resp_rdata_out == {16'h0000, $past(delay2_in)}
    && !resp_error_out)
    else $error("delay read wrong");

  main_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> mainset_out == 16'h0010)
    else $error("main setup reset wrong");

  flags_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && req_addr_in == ADDR_PSIGN
    |=> resp_rdata_out[15:0] == $past(psign_in))
    else $error("sign read wrong");

  noload_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && req_addr_in == ADDR_NOLOAD
    |=> resp_rdata_out[15:0] == $past(noload_in))
    else $error("no-load read wrong");

  peak_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && !req_write_in && req_addr_in == ADDR_PEAKST
    |=> resp_rdata_out[15:0] == $past(peak_status_in))
    else $error("peak status read wrong");

  ro_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr && req_addr_in == ADDR_CAPTURE && !xfer32_in
    |=> $stable(capture))
    else $error("read-only register changed");

  xfer_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer32_in && !(req_valid_in && !req_write_in && next_is32)
    |=> capture == $past(xfer32_data_in))
    else $error("foreign word not captured");

  gap_error_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_valid_in && req_addr_in == ADDR_COMPSET + 16'h0001
    |=> resp_error_out && resp_rdata_out == 32'h0000_0000)
    else $error("reserved gap not refused");

  trim_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> trim_a_out == RST_TRIM && trim_c_out == RST_TRIM)
    else $error("trim reset value wrong");

  peak_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    peakwin == 8'h00
    |=> !peak_done_out)
    else $error("stopped peak timer pulsed");

endmodule // mcsr_regs

// file: testbench/mcsr_host_model.sv
`timescale 1ns/100ps
module mcsr_host_model
(
  input  wire logic        clk_in,        // Device clock.
  output logic             valid_out,     // Request strobe.
  output logic             write_out,     // High for a write.
  output logic      [15:0] addr_out,      // Register address.
  output logic      [31:0] wdata_out,     // Write data.
  input  wire logic        resp_valid_in, // Answer strobe.
  input  wire logic [31:0] resp_rdata_in, // Read data.
  input  wire logic        resp_error_in  // Unmapped address flag.
);
  //--------------------------------------------------------------------
  // Request port
  //--------------------------------------------------------------------
  // Idle lines show a changing pattern so stale values cannot pass.
  initial
  begin
    valid_out = 1'b0;
    write_out = 1'b0;
    addr_out  = 16'h0000;
    wdata_out = 32'h0000_0000;
  end

  // True for the reserved gaps between the documented registers from e534 to e60f, except e539.
  function automatic logic in_gap(input logic [15:0] a);
    return (a >= 16'he534 && a <= 16'he536) ||
           (a >= 16'he53d && a <= 16'he5fe) ||
           (a >= 16'he604 && a <= 16'he607) ||
           (a >= 16'he609 && a <= 16'he60b) || (a == 16'he60f);
  endfunction

  // One request, driven after a falling edge and answered one edge later.
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic er, output logic ok);
    @(negedge clk_in);
    valid_out = 1'b1;
    write_out = wr && !in_gap(a);
    addr_out  = a;
    wdata_out = wd;
    @(negedge clk_in);
    rd        = resp_rdata_in;
    er        = resp_error_in;
    ok        = resp_valid_in;
    valid_out = 1'b0;
    write_out = ~write_out;
    addr_out  = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
endmodule // mcsr_host_model

// file: testbench/tb_mcsr_regs.sv
`timescale 1ns/100ps
module tb_mcsr_regs;
  import mcsr_pkg::*;
  //--------------------------------------------------------------------
  // Signals and tables
  //--------------------------------------------------------------------
  logic        clk_in, rst_in, rv, rw, xfer, half, pdone; // Controls.
  logic [15:0] ra, lcount, foutset, mainset;             // Requests.
  logic [31:0] wd, rdat, xdata;                          // Data words.
  logic        rok, rerr;                                // Answer flags.
  logic [9:0]  trim_a;                                   // Phase A trim.
  logic [7:0]  laccbeh;                                  // Line behaviour.
  int          num_errors = 0;                           // Mismatches.
  int          tests_run = 0;                            // Comparisons.
  localparam logic [15:0] RO_A [12] = '{16'he530, 16'he537, 16'he538,
    16'he53a, 16'he53b, 16'he53c, 16'he600, 16'he601, 16'he602,
    16'he603, 16'he608, 16'he617};
  localparam logic [31:0] RO_V [12] = '{32'h0080_0001, 32'h00ff_0002,
    32'h0090_0003, 32'h00a0_0004, 32'h00b0_0005, 32'h00c0_0006,
    32'h8101, 32'h8202, 32'h8303, 32'h8404, 32'h8505, 32'h8606};
  localparam logic [15:0] RW_A [15] = '{16'he60c, 16'he60d, 16'he60e,
    16'he610, 16'he611, 16'he612, 16'he613, 16'he614, 16'he615,
    16'he616, 16'he618, 16'he700, 16'he701, 16'he702, 16'he703};
  localparam logic [15:0] RW_R [15] = '{16'hffff, 16'hffff, 16'h01ff,
    16'h0e88, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0010,
    16'h001c, 16'h0, 16'h0078, 16'h0};
  localparam logic [31:0] RW_W [15] = '{32'hffff_1234, 32'ha5a5,
    32'h0f0f, 32'h5aa5, 32'h1111, 32'h2222, 32'h3333, 32'hffff_ffff,
    32'h0155, 32'h02aa, 32'h0001, 32'h1234_5678, 32'hff, 32'h0f, 32'h3};
  localparam logic [15:0] RW_B [15] = '{16'h1234, 16'ha5a5, 16'h0f0f,
    16'h5aa5, 16'h1111, 16'h2222, 16'h3333, 16'h03ff, 16'h0155,
    16'h02aa, 16'h0001, 16'h0078, 16'h00ff, 16'h000f, 16'h0003};
  localparam logic [15:0] GAPS [4] = '{16'he534, 16'he604, 16'he607,
    16'he60f};

  //--------------------------------------------------------------------
  // Instances
  //--------------------------------------------------------------------
  mcsr_regs mcsr_regs_inst (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(rv), .req_write_in(rw), .req_addr_in(ra),
    .req_wdata_in(wd), .resp_valid_out(rok), .resp_rdata_out(rdat),
    .resp_error_out(rerr), .xfer32_in(xfer), .xfer32_data_in(xdata),
    .a_irms_in(RO_V[1][23:0]), .a_vrms_in(RO_V[2][23:0]),
    .b_irms_in(RO_V[0][23:0]), .b_vrms_in(RO_V[3][23:0]),
    .c_irms_in(RO_V[4][23:0]), .c_vrms_in(RO_V[5][23:0]),
    .peak_status_in(RO_V[6][15:0]), .delay0_in(RO_V[7][15:0]),
    .delay1_in(RO_V[8][15:0]), .delay2_in(RO_V[9][15:0]),
    .noload_in(RO_V[10][15:0]), .psign_in(RO_V[11][15:0]),
    .half_cycle_in(half), .peak_done_out(pdone), .lcount_out(lcount),
    .zxtmo_out(), .compset_out(), .foutset_out(foutset), .fdiv1_out(),
    .fdiv2_out(), .fdiv3_out(), .trim_a_out(trim_a), .trim_b_out(),
    .trim_c_out(), .mainset_out(mainset), .measset_out(),
    .accset_out(), .laccbeh_out(laccbeh));
  mcsr_host_model mcsr_host_model_inst (.clk_in(clk_in), .valid_out(rv),
    .write_out(rw), .addr_out(ra), .wdata_out(wd), .resp_valid_in(rok),
    .resp_rdata_in(rdat), .resp_error_in(rerr));

  //--------------------------------------------------------------------
  // Tasks
  //--------------------------------------------------------------------
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Performs one access and checks its answer flags and read data.
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    logic [31:0] r;
    logic        e, k;
    mcsr_host_model_inst.access(w, a, d, r, e, k);
    check({30'h0, k, e}, {30'h0, 1'b1, err});
    check(r, w ? 32'h0 : exp);
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  //--------------------------------------------------------------------
  // Clock, watchdog and tests
  //--------------------------------------------------------------------
  // Free running 125 MHz clock.
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Cuts a hung run short well past the expected length.
  initial
  begin
    #40000;
    num_errors++;
    print_verdict();
  end

  // Main sequence of register accesses.
  initial
  begin
    rst_in = 1'b1;
    xfer   = 1'b0;
    xdata  = 32'h0;
    half   = 1'b0;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    check({lcount, foutset}, 32'hffff_0e88);
    check({6'h0, trim_a, mainset}, 32'h0000_0010);
    check({24'h0, laccbeh}, 32'h78);
    for (int i = 0; i < 15; i++)
      acc(1'b0, RW_A[i], 0, {16'h0, RW_R[i]},
          1'b0);
    for (int i = 0; i < 12; i++)
    begin
      acc(1'b0, RO_A[i], 0, RO_V[i], 1'b0);
      acc(1'b1, RO_A[i], 32'hffff_ffff, 0, 1'b0);
      acc(1'b0, RO_A[i], 0, RO_V[i], 1'b0);
    end
    acc(1'b0, ADDR_A_FIRMS, 0, RO_V[1], 1'b0);
    acc(1'b1, ADDR_C_FVRMS, 32'h1, 0, 1'b0);
    acc(1'b0, ADDR_CAPTURE, 0, RO_V[1], 1'b0);
    @(negedge clk_in);
    xfer  = 1'b1;
    xdata = 32'hc0de_1234;
    @(negedge clk_in);
    xfer  = 1'b0;
    acc(1'b1, ADDR_CAPTURE, 32'h0, 0, 1'b0);
    acc(1'b0, ADDR_CAPTURE, 0, 32'hc0de_1234, 1'b0);
    for (int i = 0; i < 15; i++)
    begin
      acc(1'b1, RW_A[i], RW_W[i], 0, 1'b0);
      acc(1'b0, RW_A[i], 0, {16'h0, RW_B[i]},
          1'b0);
    end
    check({22'h0, trim_a}, 32'h3ff);
    for (int i = 0; i < 4; i++)
      acc(1'b0, GAPS[i], 0, 0, 1'b1);
    for (int w = 2; w >= 0; w -= 2)
    begin
      acc(1'b1, ADDR_PEAKWIN, w, 0, 1'b0);
      @(negedge clk_in);
      half = 1'b1;
      @(negedge clk_in);
      check({31'h0, pdone}, 32'h0);
      @(negedge clk_in);
      half = 1'b0;
      check({31'h0, pdone}, (w == 2) ? 32'h1 : 32'h0);
      @(negedge clk_in);
      check({31'h0, pdone}, 32'h0);
    end
    print_verdict();
  end
endmodule // tb_mcsr_regs
